/* File: logic/onchip_memory_map_select.sv */
// on-chip memory map select: enable register, decode and register slave
//
// How it works
// - first CAN off: blocked, pins free, EF00 range outside only if second off.
// - second CAN off: blocked, pins free, EE00 range outside only if first off.
// - a CAN enable at one makes that controller active and reachable.
// - small RAM off sends E000-E7FF outside; on reaches internal RAM.
// - large RAM off sends C000-DFFF outside; on reaches internal RAM.
// - clock off goes outside; EC00 range outside only with both CANs off.
// - both CANs off: EE00-EFFF goes to external bus with its window setting.
// - reset: first CAN and small RAM on, second CAN and large RAM off.
// - once global enable is set, select register writes are ignored.
// - emulation mode treats every select bit as set.
// - clock off stops oscillator in power-down; else osc-off bit decides.
// - external access pin sampled at reset into flash enable bit.
// - flash enable zero keeps flash off; writing one enables it.
// - low map bit relocates only lowest 32K; upper flash stays put.
// - flash command addresses ignore bits A14 to A17.
// - command cycles may pause; unused cycles read back dummy data.
// - select register: five enables in bits 0-4, reset value 05h.
`timescale 1ns/100ps
module onchip_memory_map_select (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // register bus
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [15:0] awaddr,
  input  wire logic [2:0]  awprot,
  input  wire logic        wvalid,
  output logic             wready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  output logic             bvalid,
  input  wire logic        bready,
  output logic      [1:0]  bresp,
  input  wire logic        arvalid,
  output logic             arready,
  input  wire logic [15:0] araddr,
  input  wire logic [2:0]  arprot,
  output logic             rvalid,
  input  wire logic        rready,
  output logic      [31:0] rdata,
  output logic      [1:0]  rresp,
  // straps and modes
  input  wire logic        external_access_n,
  input  wire logic        emulation_mode,
  input  wire logic        power_down,
  // cpu access port
  input  wire logic        cpu_req,
  input  wire logic        cpu_rd,
  input  wire logic        cpu_flash_cmd,
  input  wire logic [23:0] cpu_addr,
  output logic      [4:0]  periph_hit,
  output logic             flash_hit,
  output logic             ext_req,
  output logic             access_blocked,
  output logic      [23:0] flash_cmd_addr,
  output logic             dummy_valid,
  output logic      [15:0] dummy_rdata,
  // peripheral and pin control
  output logic      [4:0]  periph_active,
  output logic             can1_pins_gpio,
  output logic             can2_pins_gpio,
  output logic             internal_flash_on,
  output logic             flash_low_map,
  output logic             calendar_osc_run
);
  // ==========================================================
  // register state
  logic [4:0]  sel_r, sel_nxt;
  logic [3:0]  sys_r, sys_nxt;
  logic        osc_off_r, osc_off_nxt;
  logic [3:0]  sys_rst;
  logic [4:0]  eff_sel;

  // ==========================================================
  // bus slave state
  logic        aw_got_r, aw_got_nxt;
  logic        w_got_r, w_got_nxt;
  logic [15:0] waddr_r, waddr_nxt;
  logic [31:0] wdat_r, wdat_nxt;
  logic [3:0]  wstb_r, wstb_nxt;
  logic        bvalid_r, bvalid_nxt;
  logic [1:0]  bresp_r, bresp_nxt;
  logic        rvalid_r, rvalid_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [1:0]  rresp_r, rresp_nxt;
  logic        wr_do;
  logic        wr_map;
  logic        rd_do;
  logic [15:0] wr_val;
  logic [31:0] status_w;

  // ==========================================================
  // decode outputs
  logic [4:0]  dec_hit;
  logic        dec_flash;
  logic        dec_ext;
  logic        dec_blk;
  logic [4:0]  hit_r, hit_nxt;
  logic        fl_r, fl_nxt;
  logic        ext_r, ext_nxt;
  logic        blk_r, blk_nxt;
  logic [23:0] cmd_addr_r, cmd_addr_nxt;
  logic        dv_r, dv_nxt;

  // emulation forces all extension peripherals on
  assign eff_sel = emulation_mode ? mem_map_pkg::PERIPH_ALL_ON : sel_r;

  // ==========================================================
  // write channel: address and data taken in either order
  assign awready = ~aw_got_r & ~bvalid_r;
  assign wready  = ~w_got_r & ~bvalid_r;
  assign wr_do   = aw_got_r & w_got_r & ~bvalid_r;
  assign wr_map  = (waddr_r == mem_map_pkg::OFS_PERIPH_SEL) ||
                   (waddr_r == mem_map_pkg::OFS_SYS_CFG) ||
                   (waddr_r == mem_map_pkg::OFS_CAL_CTRL);
  // only the low two byte lanes hold bits
  assign wr_val  = {wstb_r[1] ? wdat_r[15:8] : 8'h00, wstb_r[0] ? wdat_r[7:0] : 8'h00};

  // read channel answers one cycle after the address is taken
  assign arready = ~rvalid_r;
  assign rd_do   = arvalid & ~rvalid_r;
  assign status_w = {21'h000000, emulation_mode, sys_r[mem_map_pkg::B_XBUS],
                     sys_r[mem_map_pkg::B_FLASH], 3'h0, eff_sel};

  // bus handshake next state
  always_comb begin
    aw_got_nxt = aw_got_r;
    w_got_nxt  = w_got_r;
    waddr_nxt  = waddr_r;
    wdat_nxt   = wdat_r;
    wstb_nxt   = wstb_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt  = bresp_r;
    rvalid_nxt = rvalid_r;
    rdata_nxt  = rdata_r;
    rresp_nxt  = rresp_r;
    if (awvalid && awready) begin
      aw_got_nxt = 1'b1;
      waddr_nxt  = awaddr;
    end
    if (wvalid && wready) begin
      w_got_nxt = 1'b1;
      wdat_nxt  = wdata;
      wstb_nxt  = wstrb;
    end
    if (wr_do) begin
      aw_got_nxt = 1'b0;
      w_got_nxt  = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt  = wr_map ? mem_map_pkg::RESP_OKAY : mem_map_pkg::RESP_SLVERR;
    end else if (bvalid_r && bready) begin
      bvalid_nxt = 1'b0;
    end
    if (rd_do) begin
      rvalid_nxt = 1'b1;
      rresp_nxt  = mem_map_pkg::RESP_OKAY;
      case (araddr)
        mem_map_pkg::OFS_PERIPH_SEL: rdata_nxt = {27'h0000000, sel_r};
        mem_map_pkg::OFS_SYS_CFG:    rdata_nxt = {28'h0000000, sys_r};
        mem_map_pkg::OFS_CAL_CTRL:   rdata_nxt = {31'h00000000, osc_off_r};
        mem_map_pkg::OFS_STATUS:     rdata_nxt = status_w;
        default: begin
          rdata_nxt = 32'h00000000;
          rresp_nxt = mem_map_pkg::RESP_SLVERR;
        end
      endcase
    end else if (rvalid_r && rready) begin
      rvalid_nxt = 1'b0;
    end
  end

  // ==========================================================
  // configuration registers next state
  always_comb begin
    sel_nxt     = sel_r;
    sys_nxt     = sys_r;
    osc_off_nxt = osc_off_r;
    if (wr_do) begin
      case (waddr_r)
        mem_map_pkg::OFS_PERIPH_SEL: begin
          // frozen once the global enable is on
          if (!sys_r[mem_map_pkg::B_XBUS]) begin
            sel_nxt = wr_val[4:0];
          end
        end
        mem_map_pkg::OFS_SYS_CFG: begin
          // flash on and low map may change together in one write
          sys_nxt = wr_val[3:0];
        end
        mem_map_pkg::OFS_CAL_CTRL: begin
          osc_off_nxt = wr_val[mem_map_pkg::B_OSC_OFF];
        end
        default: begin
          sel_nxt = sel_r;
        end
      endcase
    end
  end

  // ==========================================================
  // registers; the strap is caught by the clock while reset is low
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sel_r      <= mem_map_pkg::PERIPH_SEL_RST;
      sys_r      <= sys_rst;
      osc_off_r  <= 1'b0;
      aw_got_r   <= 1'b0;
      w_got_r    <= 1'b0;
      waddr_r    <= 16'h0000;
      wdat_r     <= 32'h00000000;
      wstb_r     <= 4'h0;
      bvalid_r   <= 1'b0;
      bresp_r    <= mem_map_pkg::RESP_OKAY;
      rvalid_r   <= 1'b0;
      rdata_r    <= 32'h00000000;
      rresp_r    <= mem_map_pkg::RESP_OKAY;
    end else begin
      sel_r      <= sel_nxt;
      sys_r      <= sys_nxt;
      osc_off_r  <= osc_off_nxt;
      aw_got_r   <= aw_got_nxt;
      w_got_r    <= w_got_nxt;
      waddr_r    <= waddr_nxt;
      wdat_r     <= wdat_nxt;
      wstb_r     <= wstb_nxt;
      bvalid_r   <= bvalid_nxt;
      bresp_r    <= bresp_nxt;
      rvalid_r   <= rvalid_nxt;
      rdata_r    <= rdata_nxt;
      rresp_r    <= rresp_nxt;
    end
  end

  // config reset value: the boot strap loads the flash enable bit
  always_comb begin
    sys_rst                        = mem_map_pkg::SYS_CFG_RST;
    sys_rst[mem_map_pkg::B_FLASH] = ~external_access_n;
  end

  assign bvalid = bvalid_r;
  assign bresp  = bresp_r;
  assign rvalid = rvalid_r;
  assign rdata  = rdata_r;
  assign rresp  = rresp_r;

  // ==========================================================
  // cpu address decode
  addr_window_decode u_dec (
    .addr      (cpu_addr),
    .sel       (eff_sel),
    .flash_en  (internal_flash_on),
    .low_map   (sys_r[mem_map_pkg::B_LOWMAP]),
    .hit       (dec_hit),
    .hit_flash (dec_flash),
    .go_ext    (dec_ext),
    .blocked   (dec_blk)
  );

  // hit, flash, outside and blocked results are held from one request to the next
  always_comb begin
    hit_nxt      = hit_r;
    fl_nxt       = fl_r;
    ext_nxt      = ext_r;
    blk_nxt      = blk_r;
    cmd_addr_nxt = cmd_addr_r;
    dv_nxt       = 1'b0;
    if (cpu_req) begin
      hit_nxt = dec_hit;
      fl_nxt  = dec_flash;
      ext_nxt = dec_ext;
      blk_nxt = dec_blk;
      if (cpu_flash_cmd) begin
        cmd_addr_nxt = cpu_addr & ~mem_map_pkg::CMD_DC_MASK;
      end
      // pauses between command cycles need no state here
      dv_nxt = cpu_rd & (cpu_flash_cmd | dec_blk);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hit_r      <= 5'h00;
      fl_r       <= 1'b0;
      ext_r      <= 1'b0;
      blk_r      <= 1'b0;
      cmd_addr_r <= 24'h000000;
      dv_r       <= 1'b0;
    end else begin
      hit_r      <= hit_nxt;
      fl_r       <= fl_nxt;
      ext_r      <= ext_nxt;
      blk_r      <= blk_nxt;
      cmd_addr_r <= cmd_addr_nxt;
      dv_r       <= dv_nxt;
    end
  end

  assign periph_hit     = hit_r;
  assign flash_hit      = fl_r;
  assign ext_req        = ext_r;
  assign access_blocked = blk_r;
  assign flash_cmd_addr = cmd_addr_r;
  assign dummy_valid    = dv_r;
  assign dummy_rdata    = mem_map_pkg::DUMMY_RDATA;

  // ==========================================================
  // peripheral, pin and oscillator control
  assign periph_active     = eff_sel;
  assign can1_pins_gpio    = ~eff_sel[mem_map_pkg::B_CAN1];
  assign can2_pins_gpio    = ~eff_sel[mem_map_pkg::B_CAN2];
  // software may later overwrite the strapped value
  assign internal_flash_on = sys_r[mem_map_pkg::B_FLASH];
  assign flash_low_map     = sys_r[mem_map_pkg::B_LOWMAP];
  assign calendar_osc_run  = ~(power_down &
                               (~eff_sel[mem_map_pkg::B_RTC] | osc_off_r));

  // ==========================================================
  // checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_sel_write;
    wr_do && waddr_r == mem_map_pkg::OFS_PERIPH_SEL;
  endsequence
  sequence s_wr_taken;
    awvalid && awready && wvalid && wready;
  endsequence

  AST_RESET_SEL: assert property (disable iff (1'b0) !aresetn |=> sel_r == 5'h05)
    else $error("select register not at reset value");
  AST_SEL_LOCK: assert property (s_sel_write and sys_r[0] |=> $stable(sel_r))
    else $error("select register changed while locked");
  AST_SEL_OPEN: assert property (s_sel_write and !sys_r[0] |=> sel_r == $past(wr_val[4:0]))
    else $error("select register write lost");
  AST_EMU_ALL: assert property (emulation_mode |-> periph_active == 5'h1F)
    else $error("emulation does not enable all peripherals");
  AST_CAN_PINS: assert property (!eff_sel[0] && !eff_sel[1] |-> can1_pins_gpio && can2_pins_gpio)
    else $error("pins not freed for disabled CAN");
  AST_XRAM1_EXT: assert property (cpu_req && cpu_addr inside {[24'h00E000:24'h00E7FF]}
                                  && !eff_sel[2] |=> ext_req && !periph_hit[2])
    else $error("small RAM window not sent outside");
  AST_XRAM2_IN: assert property (cpu_req && cpu_addr inside {[24'h00C000:24'h00DFFF]}
                                 && eff_sel[3] |=> periph_hit[3] && !ext_req)
    else $error("large RAM window not internal");
  AST_RTC_BLOCK: assert property (cpu_req && cpu_addr inside {[24'h00EC00:24'h00ECFF]}
                                  && !eff_sel[4] && eff_sel[0] |=> access_blocked && !ext_req)
    else $error("clock window leaked outside while a CAN is on");
  AST_CAN_EXT: assert property (cpu_req && cpu_addr inside {[24'h00EE00:24'h00EFFF]}
                                && eff_sel[1:0] == 2'b00 |=> ext_req)
    else $error("CAN window not sent outside with both off");
  AST_OSC_STOP: assert property (power_down && !eff_sel[4] |-> !calendar_osc_run)
    else $error("oscillator runs in power-down with clock off");
  AST_CMD_MASK: assert property (cpu_req && cpu_flash_cmd |=> flash_cmd_addr[17:14] == 4'h0)
    else $error("command address bits not ignored");
  AST_DUMMY: assert property (cpu_req && cpu_rd && cpu_flash_cmd |=> dummy_valid)
    else $error("no dummy data for command read");
  AST_WR_RESP: assert property (s_wr_taken |=> ##1 bvalid)
    else $error("write response missing");
  AST_FLASH_UP: assert property (cpu_req && internal_flash_on && !cpu_flash_cmd &&
                                 cpu_addr inside {[24'h018000:24'h04FFFF]} |=> flash_hit)
    else $error("upper flash moved by low map");
endmodule

/* File: logic/mem_map_pkg.sv */
// constants for the on-chip memory map select block
package mem_map_pkg;
  // ==========================================================
  // register map (byte addresses on the register bus)
  localparam int          REG_AW         = 16;
  localparam logic [15:0] OFS_PERIPH_SEL = 16'hF024;
  localparam logic [15:0] OFS_SYS_CFG    = 16'hF028;
  localparam logic [15:0] OFS_CAL_CTRL   = 16'hF02C;
  localparam logic [15:0] OFS_STATUS     = 16'hF030;

  // ==========================================================
  // peripheral select fields and reset value
  localparam int         NWIN           = 5;
  localparam int         B_CAN1         = 0;
  localparam int         B_CAN2         = 1;
  localparam int         B_XRAM1        = 2;
  localparam int         B_XRAM2        = 3;
  localparam int         B_RTC          = 4;
  localparam logic [4:0] PERIPH_SEL_RST = 5'h05;
  localparam logic [4:0] PERIPH_ALL_ON  = 5'h1F;
  // windows that only go outside when both CAN controllers are off
  localparam logic [4:0] SHARED_WIN     = 5'h13;

  // ==========================================================
  // system configuration fields
  localparam int         SYS_CFG_W   = 4;
  localparam int         B_XBUS      = 0;
  localparam int         B_FLASH     = 1;
  localparam int         B_LOWMAP    = 2;
  localparam int         B_SEGDIS    = 3;
  localparam logic [3:0] SYS_CFG_RST = 4'h0;
  localparam int         B_OSC_OFF   = 0;
  // status fields
  localparam int         B_ST_FLASH  = 8;
  localparam int         B_ST_LOCK   = 9;
  localparam int         B_ST_EMU    = 10;

  // ==========================================================
  // cpu address windows
  localparam int          ADDR_W = 24;
  localparam logic [23:0] WIN_LO [NWIN] = '{24'h00EF00, 24'h00EE00, 24'h00E000,
                                            24'h00C000, 24'h00EC00};
  localparam logic [23:0] WIN_HI [NWIN] = '{24'h00EFFF, 24'h00EEFF, 24'h00E7FF,
                                            24'h00DFFF, 24'h00ECFF};
  localparam logic [23:0] FL_SEG0_LO  = 24'h000000;
  localparam logic [23:0] FL_SEG0_HI  = 24'h007FFF;
  localparam logic [23:0] FL_SEG1_LO  = 24'h010000;
  localparam logic [23:0] FL_SEG1_HI  = 24'h017FFF;
  localparam logic [23:0] FL_UPPER_LO = 24'h018000;
  localparam logic [23:0] FL_UPPER_HI = 24'h04FFFF;
  // command cycles do not look at these address bits
  localparam logic [23:0] CMD_DC_MASK = 24'h03C000;
  localparam logic [15:0] DUMMY_RDATA = 16'h0000;

  // ==========================================================
  // bus answers
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

/* File: logic/addr_window_decode.sv */
// address window decoder for extension peripherals and flash
`timescale 1ns/100ps
module addr_window_decode (
  input  wire logic [23:0] addr,
  input  wire logic [4:0]  sel,
  input  wire logic        flash_en,
  input  wire logic        low_map,
  output logic      [4:0]  hit,
  output logic             hit_flash,
  output logic             go_ext,
  output logic             blocked
);
  // ==========================================================
  // per-window compare
  logic [4:0] in_win;
  logic [4:0] off_blk;
  logic [4:0] off_ext;
  logic       any_can;
  logic       in_low;
  logic       in_up;

  assign any_can = sel[mem_map_pkg::B_CAN1] | sel[mem_map_pkg::B_CAN2];

  generate
    for (genvar i = 0; i < mem_map_pkg::NWIN; i++) begin : g_win
      assign in_win[i]  = (addr >= mem_map_pkg::WIN_LO[i]) && (addr <= mem_map_pkg::WIN_HI[i]);
      assign hit[i]     = in_win[i] & sel[i];
      // a CAN window stays dark while its neighbour is still on
      assign off_blk[i] = in_win[i] & ~sel[i] & mem_map_pkg::SHARED_WIN[i] & any_can;
      assign off_ext[i] = in_win[i] & ~sel[i] & ~off_blk[i];
    end
  endgenerate

  // ==========================================================
  // flash: only the low 32K moves, the upper part is fixed
  assign in_low = low_map ? (addr <= mem_map_pkg::FL_SEG0_HI)
                          : (addr >= mem_map_pkg::FL_SEG1_LO) && (addr <= mem_map_pkg::FL_SEG1_HI);
  assign in_up  = (addr >= mem_map_pkg::FL_UPPER_LO) && (addr <= mem_map_pkg::FL_UPPER_HI);
  assign hit_flash = flash_en & (in_low | in_up) & ~(|in_win);

  // everything not claimed on chip and not blocked goes to the external bus
  assign blocked = |off_blk;
  assign go_ext  = (|off_ext) | (~(|in_win) & ~hit_flash);
endmodule

/* File: tb/cpu_model.sv */
// cpu core stand-in: turns bench requests into one-cycle decode requests
`timescale 1ns/100ps
module cpu_model (
  input  wire logic        aclk,
  input  wire logic        go,
  input  wire logic [23:0] a,
  input  wire logic        rd,
  input  wire logic        cmd,
  output logic             cpu_req = 1'h0,
  output logic             cpu_rd = 1'h0,
  output logic             cpu_flash_cmd = 1'h0,
  output logic      [23:0] cpu_addr = 24'h000000
);
  // ==========================================================
  // request register
  // outside a request the address and kind are scrambled, not held,
  // so a decoder that looks at them without cpu_req gets caught
  // no jump or page-pointer state is modelled: remap ordering and
  // indirect command addressing are kept by the bench's own sequence
  always @(posedge aclk) begin
    cpu_req       <= go;
    cpu_rd        <= go ? rd : ~cpu_rd;
    cpu_flash_cmd <= go ? cmd : ~cpu_flash_cmd;
    cpu_addr      <= go ? a : ~cpu_addr;
  end
endmodule

/* File: tb/tb.sv */
// self-checking bench for the on-chip memory map select block
`timescale 1ns/100ps
module tb;
  logic        aclk = 1'h0;
  logic        aresetn = 1'h0;
  logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic [15:0] awaddr = 16'h0000, araddr = 16'h0000;
  logic [31:0] wdata = 32'h0, rdata;
  logic [3:0]  wstrb = 4'hF;
  logic [2:0]  awprot = 3'h0, arprot = 3'h0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  logic        external_access_n = 1'h0, emulation_mode = 1'h0, power_down = 1'h0;
  logic        go = 1'h0, rd = 1'h0, cmd = 1'h0, took = 1'h0;
  logic [23:0] a = 24'h0, cpu_addr, flash_cmd_addr;
  logic        cpu_req, cpu_rd, cpu_flash_cmd, flash_hit, ext_req, access_blocked, dummy_valid;
  logic [4:0]  periph_hit, periph_active;
  logic [15:0] dummy_rdata;
  logic        can1_pins_gpio, can2_pins_gpio, internal_flash_on, flash_low_map;
  logic        calendar_osc_run;
  logic [31:0] exp_q[$];
  logic [15:0] lfsr = 16'h19B7;
  int          n_errors = 0, checks = 0, cycles = 0;

  onchip_memory_map_select onchip_memory_map_select_i (.aclk, .aresetn, .awvalid, .awready,
    .awaddr, .awprot, .wvalid, .wready, .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid,
    .arready, .araddr, .arprot, .rvalid, .rready, .rdata, .rresp, .external_access_n,
    .emulation_mode, .power_down, .cpu_req, .cpu_rd, .cpu_flash_cmd, .cpu_addr, .periph_hit,
    .flash_hit, .ext_req, .access_blocked, .flash_cmd_addr, .dummy_valid, .dummy_rdata,
    .periph_active, .can1_pins_gpio, .can2_pins_gpio, .internal_flash_on, .flash_low_map,
    .calendar_osc_run);
  cpu_model cpu_model_i (.aclk, .go, .a, .rd, .cmd, .cpu_req, .cpu_rd, .cpu_flash_cmd,
    .cpu_addr);

  // ==========================================================
  // clock, watchdog, reporting
  always #2.5 aclk = ~aclk;
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      final_report();
    end
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] e);
    checks++;
    if (seen !== e) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, e, seen);
    end
  endtask
  task automatic final_report();
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  function automatic logic [15:0] step(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  // decode answer {hit, ext, blocked, flash, dummy} for a read into window i
  function automatic logic [8:0] dexp(input logic [4:0] s, input int i);
    if (s[i]) return {5'(5'h01 << i), 4'h0};
    if ((i == 0 || i == 1 || i == 4) && (s[0] | s[1])) return 9'h005;
    return 9'h008;
  endfunction

  // ==========================================================
  // result watcher: sampled mid-cycle so registered answers have settled
  always @(negedge aclk) begin
    if (took) chk("decode", {23'h0, periph_hit, ext_req, access_blocked, flash_hit,
      dummy_valid}, exp_q.pop_front());
    if (bvalid && bready) chk("bresp", {30'h0, bresp}, exp_q.pop_front());
    if (rvalid && rready) chk("rdata", {rresp, rdata[29:0]}, exp_q.pop_front());
    took = cpu_req;
  end

  // ==========================================================
  // bus and cpu drivers; each starts one edge on so strobes never double up
  task automatic wr(input logic [15:0] ad, input logic [31:0] d, input logic [1:0] r);
    logic pa, pw;
    @(posedge aclk);
    exp_q.push_back({30'h0, r});
    {pa, pw} = 2'h3;
    {awaddr, wdata, awvalid, wvalid, bready} <= {ad, d, 3'h7};
    while (pa | pw) begin
      @(negedge aclk);
      {pa, pw} = {pa & ~awready, pw & ~wready};
      @(posedge aclk);
      {awvalid, wvalid} <= {pa, pw};
    end
    do begin
      @(negedge aclk);
      pa = bvalid;
      @(posedge aclk);
    end while (pa !== 1'h1);
    bready <= 1'h0;
  endtask
  task automatic rdreg(input logic [15:0] ad, input logic [31:0] e);
    logic p;
    @(posedge aclk);
    exp_q.push_back(e);
    p = 1'h1;
    {araddr, arvalid, rready} <= {ad, 2'h3};
    while (p) begin
      @(negedge aclk);
      p = ~arready;
      @(posedge aclk);
      arvalid <= p;
    end
    do begin
      @(negedge aclk);
      p = rvalid;
      @(posedge aclk);
    end while (p !== 1'h1);
    rready <= 1'h0;
  endtask
  task automatic cpu(input logic [23:0] ad, input logic c, input logic [8:0] e);
    @(posedge aclk);
    exp_q.push_back({23'h0, e});
    {go, a, rd, cmd} <= {1'h1, ad, 1'h1, c};
    @(posedge aclk);
    go <= 1'h0;
  endtask
  // write a select value, read it back, then probe every window once
  task automatic sweep(input logic [4:0] s);
    wr(mem_map_pkg::OFS_PERIPH_SEL, {27'h0, s}, mem_map_pkg::RESP_OKAY);
    rdreg(mem_map_pkg::OFS_PERIPH_SEL, {27'h0, s});
    chk("active", {27'h0, periph_active}, {27'h0, s});
    chk("gpio", {30'h0, can1_pins_gpio, can2_pins_gpio}, {30'h0, ~s[0], ~s[1]});
    for (int i = 0; i < 5; i++) begin
      lfsr = step(lfsr);
      cpu(mem_map_pkg::WIN_LO[i] | {16'h0, lfsr[7:0]}, 1'h0, dexp(s, i));
    end
  endtask

  // ==========================================================
  // main sequence
  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    @(negedge aclk);
    chk("strap", {31'h0, internal_flash_on}, 32'h1);
    rdreg(mem_map_pkg::OFS_PERIPH_SEL, 32'h5);
    sweep(5'h05);
    sweep(5'h00);
    repeat (3) begin
      lfsr = step(lfsr);
      sweep(lfsr[4:0]);
    end
    sweep(5'h1F);
    power_down <= 1'h1;
    wr(mem_map_pkg::OFS_CAL_CTRL, 32'h1, mem_map_pkg::RESP_OKAY);
    chk("osc", {31'h0, calendar_osc_run}, 32'h0);
    wr(mem_map_pkg::OFS_CAL_CTRL, 32'h0, mem_map_pkg::RESP_OKAY);
    chk("osc", {31'h0, calendar_osc_run}, 32'h1);
    wr(mem_map_pkg::OFS_PERIPH_SEL, 32'h0, mem_map_pkg::RESP_OKAY);
    chk("osc", {31'h0, calendar_osc_run}, 32'h0);
    emulation_mode <= 1'h1;
    cpu(24'h00EE10, 1'h0, dexp(5'h1F, 1));
    chk("active", {27'h0, periph_active}, 32'h1F);
    // the decode of that request is taken one edge later, still in emulation
    @(posedge aclk);
    emulation_mode <= 1'h0;
    // low map cleared in the same write that enables the flash
    wr(mem_map_pkg::OFS_SYS_CFG, 32'h2, mem_map_pkg::RESP_OKAY);
    chk("flash", {31'h0, internal_flash_on}, 32'h1);
    cpu(24'h018000, 1'h0, 9'h002);
    cpu(24'h010000, 1'h0, 9'h002);
    wr(mem_map_pkg::OFS_SYS_CFG, 32'h6, mem_map_pkg::RESP_OKAY);
    chk("lowmap", {31'h0, flash_low_map}, 32'h1);
    cpu(24'h018000, 1'h0, 9'h002);
    cpu(24'h03C123, 1'h1, 9'h003);
    @(negedge aclk);
    @(negedge aclk);
    chk("cmd_addr", {8'h0, flash_cmd_addr}, 32'h000123);
    chk("dummy_rdata", {16'h0, dummy_rdata}, {16'h0, mem_map_pkg::DUMMY_RDATA});
    wr(mem_map_pkg::OFS_SYS_CFG, 32'h0, mem_map_pkg::RESP_OKAY);
    chk("flash", {31'h0, internal_flash_on}, 32'h0);
    cpu(24'h018000, 1'h0, 9'h008);
    wr(mem_map_pkg::OFS_SYS_CFG, 32'h1, mem_map_pkg::RESP_OKAY);
    wr(mem_map_pkg::OFS_PERIPH_SEL, 32'h1F, mem_map_pkg::RESP_OKAY);
    rdreg(mem_map_pkg::OFS_PERIPH_SEL, 32'h0);
    rdreg(mem_map_pkg::OFS_STATUS, 32'h200);
    wr(16'h0000, 32'h1, mem_map_pkg::RESP_SLVERR);
    rdreg(16'h0000, {mem_map_pkg::RESP_SLVERR, 30'h0});
    while (exp_q.size() != 0) @(posedge aclk);
    final_report();
  end
endmodule
